/* tb_top.sv */
// Testbench for the slew result and alert status registers.
// Conversions driven here; reads go through tsa_host_model.
module tb_top import tsa_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst = 1'b1, continuous = 1'b0, conv_done = 1'b0;
    logic signed [TSA_TEMP_W-1:0] temp = '0, high_limit = 14'h64, low_limit = 14'h3f9c;
    logic signed [TSA_TEMP_W-1:0] slew_limit = 14'h14;
    logic [TSA_TEMP_W-1:0] rate_scale = 14'h1, high_hyst = 14'ha, low_hyst = 14'ha;
    logic [TSA_NFLAGS-1:0] alert_enable = 8'h80;
    logic crc_fail, rd_strobe, rd_burst, alert;
    logic [7:0] rd_addr;
    logic [TSA_DATA_W-1:0] rd_data_q, d;
    logic [TSA_NFLAGS-1:0] status_q;
    logic signed [TSA_TEMP_W-1:0] slew_out;
    int fails = 0, tests_run = 0;
    always #5 ref_clk = ~ref_clk;
    tsa_regs tsa_regs_i (.ref_clk, .rst, .continuous, .conv_done, .temp, .rate_scale,
        .high_limit, .low_limit, .high_hyst, .low_hyst, .slew_limit, .alert_enable, .crc_fail,
        .rd_strobe, .rd_addr, .rd_burst, .rd_data_q, .status_q, .slew_out, .alert);
    tsa_host_model tsa_host_model_i (.ref_clk, .rd_data_q, .rd_strobe, .rd_addr, .rd_burst,
        .crc_fail);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        tsa_host_model_i.rd(a, 1'b0, 1'b0, v);
        chk(v, exp);
    endtask
    task automatic conv(input logic [13:0] t);
        @(posedge ref_clk);
        conv_done <= 1'b1;
        temp <= t;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rc(TSA_OFS_SLEW, 16'h0000);
        rc(TSA_OFS_STATUS, 16'h0000);
        rc(8'h05, 16'h0000);
        conv(14'ha);
        conv(14'h3c);
        rc(TSA_OFS_SLEW, 16'h0000);
        rc(TSA_OFS_TEMP, 16'h0000);
        rc(TSA_OFS_STATUS, 16'h0000);
        continuous <= 1'b1;
        // Nonzero first sample so an early publish would show
        conv(14'h3ff6);
        rc(TSA_OFS_SLEW, 16'h0000);
        conv(14'h28);
        chk({2'h0, slew_out}, 16'h0032);
        rc(TSA_OFS_SLEW, 16'h00c8);
        tsa_host_model_i.rd(TSA_OFS_STATUS, 1'b1, 1'b0, d);
        chk(d, 16'h0061);
        chk({8'h00, status_q}, 16'h0061);
        rc(TSA_OFS_STATUS, 16'h0061);
        rc(TSA_OFS_STATUS, 16'h0040);
        conv(14'h96);
        rc(TSA_OFS_STATUS, 16'h0075);
        conv(14'h96);
        rc(TSA_OFS_STATUS, 16'h0011);
        conv(14'h5f);
        tsa_host_model_i.rd(TSA_OFS_SLEW, 1'b0, 1'b0, d);
        chk({15'h0, d[15]}, 16'h0001);
        rc(TSA_OFS_STATUS, 16'h0031);
        conv(14'h50);
        rc(TSA_OFS_STATUS, 16'h0005);
        rate_scale <= 14'h2;
        conv(14'h3f88);
        rc(TSA_OFS_STATUS, 16'h002b);
        tsa_host_model_i.rd(8'h05, 1'b0, 1'b1, d);
        chk({15'h0, alert}, 16'h0001);
        tsa_host_model_i.rd(TSA_OFS_STATUS, 1'b0, 1'b1, d);
        chk(d, 16'h0088);
        rc(TSA_OFS_STATUS, 16'h0088);
        rc(TSA_OFS_STATUS, 16'h0008);
        chk({15'h0, alert}, 16'h0000);
        conv(14'h0);
        rc(TSA_OFS_STATUS, 16'h0063);
        continuous <= 1'b0;
        rc(TSA_OFS_SLEW, 16'h0000);
        tsa_host_model_i.rd(8'h05, 1'b0, 1'b1, d);
        // Mid-run reset with a flag standing
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rc(TSA_OFS_STATUS, 16'h0000);
        report_and_stop();
    end
endmodule
bind tsa_regs tsa_regs_assertions tsa_regs_assertions_i (.ref_clk, .rst, .continuous,
    .conv_done, .crc_fail, .rd_strobe, .rd_addr, .rd_burst, .rd_data_q, .status_q, .slew_out,
    .alert_enable, .alert);

/* tsa_host_model.sv */
// Host model: issues single or burst register reads and CRC fault pulses.
// Assumes reads are taken one edge after the strobe rises.
module tsa_host_model
    import tsa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [TSA_DATA_W-1:0] rd_data_q,
    output logic rd_strobe,
    output logic [7:0] rd_addr,
    output logic rd_burst,
    output logic crc_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {rd_strobe, rd_addr, rd_burst, crc_fail} = '0;
    task automatic rd(input logic [7:0] a, input logic b, input logic c, output logic [15:0] d);
        @(posedge ref_clk);
        rd_strobe <= 1'b1;
        rd_addr <= a;
        rd_burst <= b;
        crc_fail <= c;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
        crc_fail <= 1'b0;
        // Stale address inverted so a late capture shows up
        rd_addr <= ~a;
        @(posedge ref_clk);
        // Whole word returned; the caller picks the bits it checks
        d = rd_data_q;
    endtask
endmodule

/* tsa_pkg.sv */
// Package for the slew result and alert status register bank.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package tsa_pkg;
    localparam int TSA_DATA_W = 16;
    localparam int TSA_TEMP_W = 14;
    localparam logic [7:0] TSA_OFS_TEMP = 8'h00;
    localparam logic [7:0] TSA_OFS_SLEW = 8'h01;
    localparam logic [7:0] TSA_OFS_STATUS = 8'h02;
    localparam logic [15:0] TSA_SLEW_RESET = 16'h0000;
    localparam logic [7:0] TSA_FLAGS_RESET = 8'h00;
    localparam int TSA_SLEW_LSB_POS = 2;
    localparam int TSA_BIT_CRC = 7;
    localparam int TSA_BIT_SLEW_STS = 6;
    localparam int TSA_BIT_SLEW_FLG = 5;
    localparam int TSA_BIT_HI_STS = 4;
    localparam int TSA_BIT_LO_STS = 3;
    localparam int TSA_BIT_HI_FLG = 2;
    localparam int TSA_BIT_LO_FLG = 1;
    localparam int TSA_BIT_DRDY = 0;
    localparam int TSA_NFLAGS = 8;
endpackage

/* tsa_regs.sv */
// Slew result and alert status registers of the temperature sensor.
// Assumes the serial engine strobes reads on ref_clk and takes rd_data_q the cycle after rd_strobe.
module tsa_regs
    import tsa_pkg::*;
#(
    parameter int TW = TSA_TEMP_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic continuous,
    input wire logic conv_done,
    input wire logic signed [TW-1:0] temp,
    input wire logic [TW-1:0] rate_scale,
    input wire logic signed [TW-1:0] high_limit,
    input wire logic signed [TW-1:0] low_limit,
    input wire logic [TW-1:0] high_hyst,
    input wire logic [TW-1:0] low_hyst,
    input wire logic signed [TW-1:0] slew_limit,
    input wire logic [TSA_NFLAGS-1:0] alert_enable,
    input wire logic crc_fail,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_addr,
    input wire logic rd_burst,
    output logic [TSA_DATA_W-1:0] rd_data_q,
    output logic [TSA_NFLAGS-1:0] status_q,
    output logic signed [TW-1:0] slew_out,
    output logic alert
);
    logic signed [TW-1:0] slew_q;
    logic slew_valid_q, slew_new, slew_new_q;
    logic [TSA_NFLAGS-1:0] status_d;
    logic [TSA_DATA_W-1:0] rd_data_d, status_word, slew_word;
    logic hi_arm_q, hi_arm_d, lo_arm_q, lo_arm_d;
    logic signed [TW+1:0] t_ext, hi_ext, lo_ext, hi_rel, lo_rel;
    logic above_hi, below_hi_rel, below_lo, above_lo_rel, slew_over, slew_pos_over;
    logic status_rd_clr, temp_rd;

    tsa_slew_calc #(.TW(TW)) tsa_slew_calc_i (
        .ref_clk(ref_clk),
        .rst(rst),
        .continuous(continuous),
        .conv_done(conv_done),
        .temp(temp),
        .rate_scale(rate_scale),
        .slew_q(slew_q),
        .slew_valid_q(slew_valid_q),
        .slew_new(slew_new)
    );

    assign slew_out = slew_q;

    always_comb begin
        t_ext = (TW+2)'(temp);
        hi_ext = (TW+2)'(high_limit);
        lo_ext = (TW+2)'(low_limit);
        // Widened so limit minus hysteresis never wraps
        hi_rel = hi_ext - $signed({2'b00, high_hyst});
        lo_rel = lo_ext + $signed({2'b00, low_hyst});
        above_hi = t_ext > hi_ext;
        below_hi_rel = t_ext < hi_rel;
        below_lo = t_ext < lo_ext;
        above_lo_rel = t_ext > lo_rel;
        slew_over = slew_valid_q && (slew_q > slew_limit || slew_q < -slew_limit);
        slew_pos_over = slew_valid_q && !slew_q[TW-1] && slew_q > slew_limit;
    end

    // Burst status reads never clear; a temp read clears DRDY either way
    assign status_rd_clr = rd_strobe && !rd_burst && rd_addr == TSA_OFS_STATUS;
    assign temp_rd = rd_strobe && rd_addr == TSA_OFS_TEMP;

    always_comb begin
        status_d = status_q;
        hi_arm_d = hi_arm_q;
        lo_arm_d = lo_arm_q;
        if (status_rd_clr) begin
            status_d[TSA_BIT_CRC] = 1'b0;
            status_d[TSA_BIT_SLEW_FLG] = 1'b0;
            status_d[TSA_BIT_HI_FLG] = 1'b0;
            status_d[TSA_BIT_LO_FLG] = 1'b0;
        end
        if (status_rd_clr || temp_rd) begin
            status_d[TSA_BIT_DRDY] = 1'b0;
        end
        // Sets follow clears so a coincident event survives
        if (crc_fail) begin
            status_d[TSA_BIT_CRC] = 1'b1;
        end
        status_d[TSA_BIT_SLEW_STS] = slew_pos_over;
        // Judged a cycle late, once slew_q holds the new value
        if (slew_new_q && slew_over) begin
            status_d[TSA_BIT_SLEW_FLG] = 1'b1;
        end
        if (!continuous) begin
            status_d[TSA_BIT_SLEW_STS] = 1'b0;
        end
        if (conv_done) begin
            status_d[TSA_BIT_DRDY] = 1'b1;
            if (above_hi) begin
                status_d[TSA_BIT_HI_STS] = 1'b1;
            end else if (below_hi_rel) begin
                status_d[TSA_BIT_HI_STS] = 1'b0;
            end
            if (below_lo) begin
                status_d[TSA_BIT_LO_STS] = 1'b1;
            end else if (above_lo_rel) begin
                status_d[TSA_BIT_LO_STS] = 1'b0;
            end
            // High flag: set on crossing up, and set again when rearmed below the lower threshold
            if (above_hi && hi_arm_q) begin
                status_d[TSA_BIT_HI_FLG] = 1'b1;
                hi_arm_d = 1'b0;
            end else if (below_hi_rel && !hi_arm_q) begin
                status_d[TSA_BIT_HI_FLG] = 1'b1;
                hi_arm_d = 1'b1;
            end
            if (below_lo && lo_arm_q) begin
                status_d[TSA_BIT_LO_FLG] = 1'b1;
                lo_arm_d = 1'b0;
            end else if (above_lo_rel && !lo_arm_q) begin
                status_d[TSA_BIT_LO_FLG] = 1'b1;
                lo_arm_d = 1'b1;
            end
        end
    end

    always_comb begin
        status_word = '0;
        status_word[TSA_NFLAGS-1:0] = status_q;
        slew_word = TSA_SLEW_RESET;
        slew_word[TSA_DATA_W-1:TSA_SLEW_LSB_POS] = slew_q;
        rd_data_d = rd_data_q;
        // Captured from pre-clear state in the strobe cycle
        if (rd_strobe) begin
            unique case (rd_addr)
                TSA_OFS_SLEW: rd_data_d = slew_word;
                TSA_OFS_STATUS: rd_data_d = status_word;
                default: rd_data_d = '0;
            endcase
        end
    end

    // Alert stays a level; comparator or interrupt framing lies outside
    assign alert = |(status_q & alert_enable);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_q <= TSA_FLAGS_RESET;
            hi_arm_q <= 1'b1;
            lo_arm_q <= 1'b1;
            rd_data_q <= '0;
            slew_new_q <= 1'b0;
        end else begin
            slew_new_q <= slew_new;
            status_q <= status_d;
            hi_arm_q <= hi_arm_d;
            lo_arm_q <= lo_arm_d;
            rd_data_q <= rd_data_d;
        end
    end
endmodule

/* tsa_regs_assertions.sv */
// Checker for the slew result and alert status registers.
// Bound to tsa_regs; sees only its ports.
module tsa_regs_assertions
    import tsa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic continuous,
    input wire logic conv_done,
    input wire logic crc_fail,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_addr,
    input wire logic rd_burst,
    input wire logic [TSA_DATA_W-1:0] rd_data_q,
    input wire logic [TSA_NFLAGS-1:0] status_q,
    input wire logic signed [TSA_TEMP_W-1:0] slew_out,
    input wire logic [TSA_NFLAGS-1:0] alert_enable,
    input wire logic alert
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire st = rd_strobe && rd_addr == TSA_OFS_STATUS;
    wire clr = st && !rd_burst;
    wire tr = rd_strobe && rd_addr == TSA_OFS_TEMP;
    wire sr = rd_strobe && rd_addr == TSA_OFS_SLEW;
    rsvd_zero_a: assert property (st |=> rd_data_q[15:8] == 8'h00)
        else $error("rsvd");
    slew_pad_a: assert property (sr |=> rd_data_q[1:0] == 2'h0)
        else $error("slew pad");
    slew_idle_a: assert property ((!continuous) [*2] |-> slew_out == '0)
        else $error("slew");
    snap_read_a: assert property (st |=> rd_data_q[7:0] == $past(status_q))
        else $error("snap");
    rc_keep_a: assert property (status_q[7] && !clr |=> status_q[7])
        else $error("kept");
    crc_set_a: assert property (crc_fail |=> status_q[7])
        else $error("crc set");
    crc_clr_a: assert property (clr && !crc_fail |=> !status_q[7])
        else $error("crc clr");
    drdy_set_a: assert property (conv_done |=> status_q[0])
        else $error("drdy set");
    drdy_clr_a: assert property ((clr || tr) && !conv_done |=> !status_q[0])
        else $error("drdy clr");
    hi_hold_a: assert property (status_q[4] && !conv_done |=> status_q[4])
        else $error("hi");
    lo_hold_a: assert property (status_q[3] && !conv_done |=> status_q[3])
        else $error("lo");
    live_off_a: assert property (!continuous |=> !status_q[6])
        else $error("live");
    alert_or_a: assert property (alert == |(status_q & alert_enable))
        else $error("alert");
    cover property (st && rd_burst);
    cover property (crc_fail && clr);
    cover property (conv_done && continuous);
endmodule

/* tsa_slew_calc.sv */
// Slew result tracker: forms the slew value from consecutive conversions.
// Assumes conv_done is a one-cycle pulse on ref_clk with temp valid beside it.
module tsa_slew_calc
    import tsa_pkg::*;
#(
    parameter int TW = TSA_TEMP_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic continuous,
    input wire logic conv_done,
    input wire logic signed [TW-1:0] temp,
    input wire logic [TW-1:0] rate_scale,
    output logic signed [TW-1:0] slew_q,
    output logic slew_valid_q,
    output logic slew_new
);
    logic signed [TW-1:0] prev_q, prev_d, slew_d;
    logic have_prev_q, have_prev_d, slew_valid_d;
    logic signed [TW:0] diff;
    logic signed [2*TW+1:0] prod;

    // Rate = delta per conversion times conversions per second (scale input)
    always_comb begin
        diff = {temp[TW-1], temp} - {prev_q[TW-1], prev_q};
        prod = diff * $signed({1'b0, rate_scale});
        prev_d = prev_q;
        have_prev_d = have_prev_q;
        slew_d = slew_q;
        slew_valid_d = slew_valid_q;
        slew_new = 1'b0;
        if (!continuous) begin
            have_prev_d = 1'b0;
            slew_valid_d = 1'b0;
            slew_d = '0;
        end else if (conv_done) begin
            prev_d = temp;
            have_prev_d = 1'b1;
            if (have_prev_q) begin
                // Second and later conversions only
                slew_d = prod[TW-1:0];
                slew_valid_d = 1'b1;
                slew_new = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_q <= '0;
            have_prev_q <= 1'b0;
            slew_q <= '0;
            slew_valid_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            have_prev_q <= have_prev_d;
            slew_q <= slew_d;
            slew_valid_q <= slew_valid_d;
        end
    end
endmodule
